/* File: common/pew_regs.svh */
// Purpose: constants for the endpoint power, wake and reset block
// Assumes: 50 MHz core clock
// Notes: power-state codes match the endpoint MAC's state field
`ifndef PEW_REGS_SVH
`define PEW_REGS_SVH

// power-state codes
`define PEW_PM_W 2
`define PEW_PM_D0 2'h0
`define PEW_PM_D1 2'h1
`define PEW_PM_D2 2'h2
`define PEW_PM_D3 2'h3

// auxiliary-power detection forced value
`define PEW_AUX_FORCE 2'h3

// outbound interrupt lines and irq identity width
`define PEW_OIRQ_N 2
`define PEW_IRQ_SRC_W 1

// timing
`define PEW_CLK_PERIOD_NS 20
`define PEW_RST_HOLD_NS 1000
`define PEW_RST_HOLD_CYC ((`PEW_RST_HOLD_NS + `PEW_CLK_PERIOD_NS - 1) / `PEW_CLK_PERIOD_NS)

`endif

/* File: common/pew_pkg.sv */
// Purpose: types for the endpoint power, wake and reset block
// Assumes: constants come from pew_regs.svh
// Notes: none
`include "pew_regs.svh"

package pew_pkg;

    typedef struct packed {
        logic suppress_link_beacon;
        logic wakeup_output_polarity;
        logic wake_oe_mode;
    } pew_wake_cfg_t;

    typedef struct packed {
        logic [`PEW_OIRQ_N-1:0] irq_ena;
        logic no_wakeup_from_irq_change;
    } pew_irq_cfg_t;

    typedef enum logic [1:0] {
        PEW_RST_IDLE = 2'h1,
        PEW_RST_HOLD = 2'h2
    } pew_rst_state_t;

endpackage : pew_pkg

/* File: design/pew_soft_rst.sv */
// Purpose: full-device reset pulse from the soft chip reset bit
// Assumes: soft_chip_rst is a one-cycle write strobe
// Notes: the endpoint MAC reset is not touched here
`include "pew_regs.svh"

module pew_soft_rst #(
    parameter int HOLD_CYC = `PEW_RST_HOLD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // control
    input wire logic soft_chip_rst,
    // device reset
    output logic chip_rst_n
);
    import pew_pkg::*;

    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

    pew_rst_state_t state_r;
    pew_rst_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic chip_rst_n_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            PEW_RST_IDLE: begin
                cnt_nxt = '0;
                if (soft_chip_rst) begin
                    state_nxt = PEW_RST_HOLD;
                end
            end
            PEW_RST_HOLD: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == LAST) begin
                    state_nxt = PEW_RST_IDLE;
                end
            end
            default: begin
                state_nxt = PEW_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= PEW_RST_IDLE;
            cnt_r <= '0;
            chip_rst_n_r <= 1'b1;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            chip_rst_n_r <= (state_nxt != PEW_RST_HOLD);
        end
    end

    assign chip_rst_n = chip_rst_n_r;

    sequence s_rst_req;
        clk_en && soft_chip_rst && (state_r == PEW_RST_IDLE);
    endsequence

    property p_rst_start;
        @(posedge clk) disable iff (!arst_n)
        s_rst_req |=> !chip_rst_n;
    endproperty

    rst_start_a: assert property (p_rst_start) else $error("soft reset did not assert device reset");

    rst_len_a: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && state_r == PEW_RST_HOLD && cnt_r == LAST) |=> chip_rst_n)
        else $error("device reset held too long");

    rst_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && state_r == PEW_RST_HOLD && cnt_r != LAST) |=> !chip_rst_n)
        else $error("device reset released early");

endmodule : pew_soft_rst

/* File: design/pew_top.sv */
// Purpose: endpoint power state reporting, wake and device reset control
// Assumes: all inputs synchronous to clk; bus-master and frame DMA requests are pulses
// Notes: switching core is never steered from here
// How it works
// - power state field carries D0, D1 or D3; the D2 code is ignored.
// - no output steers the switching core; software reacts via the irq.
// - aux detect config equal to 3 reports PME capability in D3c.
// - registered power state is output; any change sets the sticky change flag.
// - sticky flag reaches the interrupt only while its enable is set.
// - identity output shows active sources; nonzero means interrupt asserted.
// - PME messages only with PME enable set and state not D0.
// - bus-master or frame DMA outbound request while powered down raises PME.
// - enabled outbound irq status change raises PME unless wakeup disable set.
// - beacon transmits in D3 unless beacon suppressed.
// - suppressing the beacon enables the WAKE output instead.
// - WAKE active level follows the polarity bit.
// - WAKE drive scheme: always driven or output-enable controlled.
// - protocol reset reaches only the MAC reset output.
// - soft chip reset pulses the full-device reset.
`include "pew_regs.svh"

module pew_top #(
    parameter int RST_HOLD = `PEW_RST_HOLD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // power state and capability
    input wire logic [`PEW_PM_W-1:0] mac_power_state_field,
    input wire logic pme_en,
    input wire logic [1:0] aux_detect_cfg,
    output logic pme_d3c_capable,
    output logic [`PEW_PM_W-1:0] power_state_field,
    // sticky event and interrupt
    input wire logic power_state_change_irq_en,
    input wire logic power_state_change_clr,
    output logic power_state_change_flag,
    output logic [`PEW_IRQ_SRC_W-1:0] active_endpoint_irq_sources,
    output logic ep_irq,
    // wake sources
    input wire logic system_bus_masters_req,
    input wire logic frame_dma_engine_req,
    input wire logic [`PEW_OIRQ_N-1:0] outbound_irq_status,
    input wire pew_pkg::pew_irq_cfg_t outbound_irq_common_cfg,
    output logic pme_msg_req,
    // beacon and wake pin
    input wire pew_pkg::pew_wake_cfg_t wakeup_beacon_cfg,
    output logic beacon_tx_en,
    output logic wake_out,
    output logic wake_oe,
    // resets
    input wire logic pcie_proto_rst_n,
    input wire logic soft_chip_rst,
    output logic mac_rst_n,
    output logic chip_rst_n
);
    import pew_pkg::*;

    logic [`PEW_PM_W-1:0] state_r;
    logic flag_r;
    logic [`PEW_IRQ_SRC_W-1:0] ident_r;
    logic aux_r;
    logic pme_r;
    logic [`PEW_OIRQ_N-1:0] oirq_prev_r;
    logic beacon_r;
    logic wake_act_r;
    logic wake_out_r;
    logic wake_oe_r;

    // any legal code other than D0 counts as powered down
    function automatic logic is_powered_down(input logic [`PEW_PM_W-1:0] st);
        return st != `PEW_PM_D0;
    endfunction : is_powered_down

    // power state tracking
    wire pm_legal = (mac_power_state_field != `PEW_PM_D2);
    wire [`PEW_PM_W-1:0] state_nxt = pm_legal ? mac_power_state_field : state_r;
    wire state_chg = (state_nxt != state_r);
    wire powered_down = is_powered_down(state_r);

    // sticky flag: a new change beats a clear in the same cycle
    wire flag_nxt = state_chg | (flag_r & ~power_state_change_clr);
    wire [`PEW_IRQ_SRC_W-1:0] ident_nxt = flag_nxt & power_state_change_irq_en;

    // wake sources
    wire [`PEW_OIRQ_N-1:0] oirq_chg = (outbound_irq_status ^ oirq_prev_r) & outbound_irq_common_cfg.irq_ena;
    wire irq_wake = (|oirq_chg) & ~outbound_irq_common_cfg.no_wakeup_from_irq_change;
    wire req_wake = system_bus_masters_req | frame_dma_engine_req;
    wire pme_event = pme_en & powered_down & (req_wake | irq_wake);

    // beacon and wake pin
    wire suppress = wakeup_beacon_cfg.suppress_link_beacon;
    wire pol = wakeup_beacon_cfg.wakeup_output_polarity;
    wire beacon_nxt = (state_nxt == `PEW_PM_D3) & ~suppress;
    wire wake_act_nxt = suppress & is_powered_down(state_nxt) & (pme_event | wake_act_r);
    wire wake_lvl_nxt = wake_act_nxt ? pol : ~pol;
    wire wake_oe_nxt = suppress & (~wakeup_beacon_cfg.wake_oe_mode | wake_act_nxt);
    wire wake_out_nxt = wakeup_beacon_cfg.wake_oe_mode ? pol : wake_lvl_nxt;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= `PEW_PM_D0;
            flag_r <= 1'b0;
            ident_r <= '0;
            aux_r <= 1'b0;
            oirq_prev_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            flag_r <= flag_nxt;
            ident_r <= ident_nxt;
            aux_r <= (aux_detect_cfg == `PEW_AUX_FORCE);
            oirq_prev_r <= outbound_irq_status;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pme_r <= 1'b0;
            beacon_r <= 1'b0;
            wake_act_r <= 1'b0;
            wake_out_r <= 1'b0;
            wake_oe_r <= 1'b0;
        end else if (clk_en) begin
            pme_r <= pme_event;
            beacon_r <= beacon_nxt;
            wake_act_r <= wake_act_nxt;
            wake_out_r <= wake_out_nxt;
            wake_oe_r <= wake_oe_nxt;
        end
    end

    assign power_state_field = state_r;
    assign power_state_change_flag = flag_r;
    assign active_endpoint_irq_sources = ident_r;
    assign ep_irq = |ident_r;
    assign pme_d3c_capable = aux_r;
    assign pme_msg_req = pme_r;
    assign beacon_tx_en = beacon_r;
    assign wake_out = wake_out_r;
    assign wake_oe = wake_oe_r;
    // protocol reset goes to the MAC only, never to the device reset
    assign mac_rst_n = pcie_proto_rst_n;

    // device-wide reset; the host waits out the reset before restoring config
    pew_soft_rst #(
        .HOLD_CYC(RST_HOLD)
    ) u_soft_rst (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .soft_chip_rst(soft_chip_rst),
        .chip_rst_n(chip_rst_n)
    );

    sequence s_chg;
        clk_en && state_chg;
    endsequence

    sequence s_keep;
        clk_en && flag_r && !power_state_change_clr;
    endsequence

    sequence s_masked;
        clk_en && !power_state_change_irq_en;
    endsequence

    sequence s_wake_evt;
        clk_en && suppress && pme_event && is_powered_down(mac_power_state_field);
    endsequence

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // power state, flag and interrupt
    flag_set_a: assert property (s_chg |=> power_state_change_flag) else $error("change flag not set");
    flag_sticky_a: assert property (s_keep |=> power_state_change_flag) else $error("flag lost");
    flag_clr_a: assert property (clk_en && power_state_change_clr && !state_chg
        |=> !power_state_change_flag) else $error("change flag not cleared");
    field_hold_a: assert property (clk_en && mac_power_state_field == `PEW_PM_D2 |=> $stable(power_state_field))
        else $error("ignored state code taken");
    irq_masked_a: assert property (s_masked |=> !ep_irq) else $error("irq while disabled");
    irq_on_a: assert property (clk_en && power_state_change_irq_en
        && (state_chg || (power_state_change_flag && !power_state_change_clr)) |=> ep_irq) else $error("irq not raised");
    ident_src_a: assert property (ep_irq |-> power_state_change_flag) else $error("irq without source");
    aux_cap_a: assert property (clk_en && aux_detect_cfg == 2'h3 |=> pme_d3c_capable)
        else $error("aux capability not reported");

    // pme requests
    pme_gate_a: assert property (pme_msg_req && $past(clk_en) |-> $past(pme_en) && $past(state_r) != 2'h0)
        else $error("pme outside powered-down state");
    pme_off_a: assert property (clk_en && !(pme_en && powered_down) |=> !pme_msg_req)
        else $error("pme while not allowed");
    pme_req_a: assert property (clk_en && pme_en && powered_down && system_bus_masters_req |=> pme_msg_req)
        else $error("request did not wake");
    pme_dma_a: assert property (clk_en && pme_en && powered_down && frame_dma_engine_req |=> pme_msg_req)
        else $error("dma request did not wake");
    pme_irq_a: assert property (clk_en && pme_en && powered_down && irq_wake |=> pme_msg_req)
        else $error("irq change did not wake");
    pme_irq_dis_a: assert property (clk_en && outbound_irq_common_cfg.no_wakeup_from_irq_change
        && !req_wake |=> !pme_msg_req) else $error("irq change woke while disabled");

    // beacon and wake
    beacon_d3_a: assert property (beacon_tx_en |-> power_state_field == 2'h3)
        else $error("beacon outside D3");
    beacon_on_a: assert property (clk_en && mac_power_state_field == `PEW_PM_D3 && !suppress |=> beacon_tx_en)
        else $error("beacon missing in D3");
    beacon_sup_a: assert property (clk_en && suppress |=> !beacon_tx_en) else $error("beacon not suppressed");
    wake_drive_a: assert property (clk_en && suppress && !wakeup_beacon_cfg.wake_oe_mode |=> wake_oe)
        else $error("wake not driven");
    wake_oe_off_a: assert property (clk_en && !suppress |=> !wake_oe) else $error("wake driven with beacon");
    wake_assert_a: assert property (s_wake_evt |=> wake_out == $past(pol) && wake_oe)
        else $error("wake not asserted");
    wake_release_a: assert property (clk_en && mac_power_state_field == `PEW_PM_D0 && wakeup_beacon_cfg.wake_oe_mode
        |=> !wake_oe) else $error("wake held in D0");

    // resets
    mac_rst_a: assert property (!pcie_proto_rst_n && chip_rst_n && !soft_chip_rst |=> chip_rst_n)
        else $error("protocol reset reached device reset");

endmodule : pew_top

/* File: testbench/pew_host_model.sv */
// Purpose: host model setting endpoint power state, PME enable and protocol reset
// Assumes: bench requests change off the rising edge
// Notes: requests take effect on the next rising edge
`include "pew_regs.svh"

module pew_host_model (
    // clock
    input wire logic clk,
    // bench requests
    input wire logic [1:0] tgt_state,
    input wire logic tgt_pme,
    input wire logic tgt_rst,
    // endpoint side
    output logic [`PEW_PM_W-1:0] mac_power_state_field,
    output logic pme_en,
    output logic pcie_proto_rst_n
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge clk) begin
        mac_power_state_field <= tgt_state;
        pme_en <= tgt_pme;
        pcie_proto_rst_n <= ~tgt_rst;
    end
endmodule : pew_host_model

/* File: testbench/pew_top_tb.sv */
// Purpose: self-checking bench for the endpoint power, wake and reset block
// Assumes: inputs move on the falling edge, outputs read on a later one
// Notes: device reset hold shortened to 4 cycles
`include "pew_regs.svh"

module pew_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pew_pkg::*;
    localparam int HOLD = 4;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] tgt_state = 2'h0;
    logic tgt_pme = 1'b0;
    logic tgt_rst = 1'b0;
    logic [1:0] aux_detect_cfg = 2'h0;
    logic power_state_change_irq_en = 1'b0;
    logic power_state_change_clr = 1'b0;
    logic system_bus_masters_req = 1'b0;
    logic frame_dma_engine_req = 1'b0;
    logic soft_chip_rst = 1'b0;
    logic [`PEW_OIRQ_N-1:0] outbound_irq_status = '0;
    pew_irq_cfg_t outbound_irq_common_cfg = '0;
    pew_wake_cfg_t wakeup_beacon_cfg = '0;
    logic [`PEW_PM_W-1:0] mac_power_state_field, power_state_field;
    logic [`PEW_IRQ_SRC_W-1:0] active_endpoint_irq_sources;
    logic pme_en, pcie_proto_rst_n, pme_d3c_capable, power_state_change_flag, ep_irq;
    logic pme_msg_req, beacon_tx_en, wake_out, wake_oe, mac_rst_n, chip_rst_n;
    int n_fail = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    pew_host_model host (.clk, .tgt_state, .tgt_pme, .tgt_rst, .mac_power_state_field, .pme_en, .pcie_proto_rst_n);

    pew_top #(.RST_HOLD(HOLD)) uut (.clk, .arst_n, .clk_en, .mac_power_state_field, .pme_en, .aux_detect_cfg,
        .pme_d3c_capable, .power_state_field, .power_state_change_irq_en, .power_state_change_clr,
        .power_state_change_flag, .active_endpoint_irq_sources, .ep_irq, .system_bus_masters_req,
        .frame_dma_engine_req, .outbound_irq_status, .outbound_irq_common_cfg, .pme_msg_req,
        .wakeup_beacon_cfg, .beacon_tx_en, .wake_out, .wake_oe, .pcie_proto_rst_n, .soft_chip_rst,
        .mac_rst_n, .chip_rst_n);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic go_state(input logic [1:0] s);
        tgt_state = s;
        tick(2);
    endtask : go_state

    // one wake stimulus, then pulse seen for exactly one cycle or not at all
    task automatic pme_try(input logic b, input logic d, input logic [1:0] st, input logic exp);
        system_bus_masters_req = b;
        frame_dma_engine_req = d;
        outbound_irq_status = st;
        tick(1);
        system_bus_masters_req = 1'b0;
        frame_dma_engine_req = 1'b0;
        check({7'h00, pme_msg_req}, {7'h00, exp});
        tick(1);
        check(pme_msg_req, 8'h00);
    endtask : pme_try

    task automatic t_reset();
        check(power_state_field, 8'h00);
        check(power_state_change_flag, 8'h00);
        check(ep_irq, 8'h00);
        check(beacon_tx_en, 8'h00);
        check(chip_rst_n, 8'h01);
    endtask : t_reset

    task automatic t_state_irq();
        go_state(`PEW_PM_D1);
        check(power_state_field, 8'h01);
        check(power_state_change_flag, 8'h01);
        check(ep_irq, 8'h00);
        power_state_change_irq_en = 1'b1;
        tick(1);
        check(active_endpoint_irq_sources, 8'h01);
        check(ep_irq, 8'h01);
        go_state(`PEW_PM_D2);
        check(power_state_field, 8'h01);
        check(power_state_change_flag, 8'h01);
        power_state_change_clr = 1'b1;
        tick(1);
        power_state_change_clr = 1'b0;
        check(power_state_change_flag, 8'h00);
        check(active_endpoint_irq_sources, 8'h00);
        aux_detect_cfg = `PEW_AUX_FORCE;
        tick(1);
        check(pme_d3c_capable, 8'h01);
        aux_detect_cfg = 2'h1;
        tick(1);
        check(pme_d3c_capable, 8'h00);
    endtask : t_state_irq

    task automatic t_pme();
        tgt_pme = 1'b1;
        outbound_irq_common_cfg.irq_ena = 2'b01;
        go_state(`PEW_PM_D0);
        pme_try(1'b1, 1'b1, 2'b01, 1'b0);
        go_state(`PEW_PM_D1);
        pme_try(1'b1, 1'b0, 2'b01, 1'b1);
        pme_try(1'b0, 1'b1, 2'b01, 1'b1);
        pme_try(1'b0, 1'b0, 2'b00, 1'b1);
        pme_try(1'b0, 1'b0, 2'b10, 1'b0);
        outbound_irq_common_cfg.no_wakeup_from_irq_change = 1'b1;
        pme_try(1'b0, 1'b0, 2'b11, 1'b0);
        outbound_irq_common_cfg.no_wakeup_from_irq_change = 1'b0;
        tgt_pme = 1'b0;
        tick(2);
        pme_try(1'b1, 1'b0, 2'b10, 1'b0);
    endtask : t_pme

    task automatic t_wake();
        tgt_pme = 1'b1;
        go_state(`PEW_PM_D3);
        check(beacon_tx_en, 8'h01);
        check(wake_oe, 8'h00);
        wakeup_beacon_cfg.suppress_link_beacon = 1'b1;
        wakeup_beacon_cfg.wakeup_output_polarity = 1'b1;
        tick(1);
        check(beacon_tx_en, 8'h00);
        check(wake_oe, 8'h01);
        check(wake_out, 8'h00);
        pme_try(1'b1, 1'b0, outbound_irq_status, 1'b1);
        check(wake_out, 8'h01);
        wakeup_beacon_cfg.wake_oe_mode = 1'b1;
        tick(1);
        check(wake_oe, 8'h01);
        go_state(`PEW_PM_D0);
        check(wake_oe, 8'h00);
        check(wake_out, 8'h01);
        wakeup_beacon_cfg = 3'b100;
        tick(1);
        check(wake_out, 8'h01);
    endtask : t_wake

    task automatic t_resets();
        tgt_rst = 1'b1;
        tick(2);
        check(mac_rst_n, 8'h00);
        check(chip_rst_n, 8'h01);
        tgt_rst = 1'b0;
        tick(2);
        soft_chip_rst = 1'b1;
        for (int i = 0; i <= HOLD; i++) begin
            tick(1);
            soft_chip_rst = (i == 1);
            check(chip_rst_n, (i < HOLD) ? 8'h00 : 8'h01);
            check(mac_rst_n, 8'h01);
        end
    endtask : t_resets

    // set beats clear in one cycle; clk_en low freezes state and the pme pulse
    task automatic t_freeze();
        tgt_state = `PEW_PM_D1;
        tick(1);
        power_state_change_clr = 1'b1;
        tick(1);
        power_state_change_clr = 1'b0;
        check(power_state_change_flag, 8'h01);
        check(power_state_field, 8'h01);
        wakeup_beacon_cfg = '0;
        clk_en = 1'b0;
        tgt_state = `PEW_PM_D3;
        tick(3);
        check(power_state_field, 8'h01);
        check(beacon_tx_en, 8'h00);
        clk_en = 1'b1;
        tick(1);
        check(power_state_field, 8'h03);
        check(beacon_tx_en, 8'h01);
        system_bus_masters_req = 1'b1;
        tick(1);
        system_bus_masters_req = 1'b0;
        clk_en = 1'b0;
        check(pme_msg_req, 8'h01);
        tick(2);
        check(pme_msg_req, 8'h01);
        clk_en = 1'b1;
        tick(1);
        check(pme_msg_req, 8'h00);
    endtask : t_freeze

    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        tick(1);
        t_reset();
        t_state_irq();
        t_pme();
        t_wake();
        t_resets();
        t_freeze();
        finish_test();
    end

    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule : pew_top_tb
